// ---- hw/cfg_msg_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfg_msg_port
   import cfg_msg_pkg::*;
#(
   parameter int NUM_FUNC = 2,
   parameter int NUM_DW = 16,
   parameter int MGMT_LAT = 2,
   parameter int FIFO_DEPTH = 8,
   // Arbitrary identity dword, reset value of dword zero
   parameter logic [31:0] ID_DWORD = 32'h1234_5678
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_msg_valid,
   input wire msg_s i_msg,
   output logic o_msg_ready,
   output logic o_msg_received,
   output logic [4:0] o_msg_type,
   output logic [7:0] o_msg_data,
   input wire logic i_root_port,
   input wire mgmt_req_s i_mgmt_req,
   input wire logic i_mgmt_write,
   input wire logic i_mgmt_read,
   input wire logic i_mgmt_type1_override,
   output logic [31:0] o_mgmt_read_data,
   output logic o_mgmt_done
);
   localparam int NUM_WORDS = NUM_FUNC * NUM_DW;
   localparam int IDX_W = (NUM_WORDS > 1) ? $clog2(NUM_WORDS) : 1;
   localparam int MGMT_MAX = MGMT_LAT + 1;
   localparam mgmt_cnt_t LAT_LAST = mgmt_cnt_t'(MGMT_LAT - 1);

   typedef enum logic [1:0] {
      s_idle = 2'b01,
      s_send = 2'b10
   } ser_state_e;

   typedef enum logic [2:0] {
      m_idle = 3'b001,
      m_busy = 3'b010,
      m_done = 3'b100
   } mgmt_state_e;

   // ==========================================================
   // Message buffer
   // Back-pressure stops at the link side; the user side never stalls
   logic fifo_valid;
   msg_s fifo_msg;
   logic fifo_pop;
   frame_s head;

   msg_fifo #(
      .WIDTH($bits(msg_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_in_valid(i_msg_valid),
      .i_in_data(i_msg),
      .o_in_ready(o_msg_ready),
      .o_out_valid(fifo_valid),
      .o_out_data(fifo_msg),
      .i_out_ready(fifo_pop)
   );

   // ==========================================================
   // Message serialiser
   ser_state_e ser_state_r;
   ser_state_e ser_state_nxt;
   logic [3:0] left_r;
   logic [3:0] left_nxt;
   logic [63:0] shift_r;
   logic [63:0] shift_nxt;
   logic rx_r;
   logic rx_nxt;
   logic [4:0] type_r;
   logic [4:0] type_nxt;
   logic [7:0] data_r;
   logic [7:0] data_nxt;
   msg_s cur_r;
   msg_s cur_nxt;

   // Head is popped only while idle; reserved codes are dropped
   assign head = build_frame(fifo_msg);
   assign fifo_pop = (ser_state_r == s_idle);
   wire start = fifo_pop && fifo_valid && (head.len != LEN_NONE);

   // Next-state of the serialiser
   always_comb begin
      ser_state_nxt = ser_state_r;
      left_nxt = left_r;
      shift_nxt = shift_r;
      rx_nxt = rx_r;
      type_nxt = type_r;
      data_nxt = data_r;
      cur_nxt = cur_r;
      unique case (ser_state_r)
         s_idle: begin
            if (start) begin
               rx_nxt = 1'b1;
               type_nxt = fifo_msg.kind;
               data_nxt = head.bytes[7:0];
               shift_nxt = {8'h00, head.bytes[63:8]};
               left_nxt = head.len - LEN_ONE;
               cur_nxt = fifo_msg;
               ser_state_nxt = s_send;
            end
         end
         s_send: begin
            if (left_r == LEN_NONE) begin
               // Returning to idle costs one low cycle before the next
               rx_nxt = 1'b0;
               ser_state_nxt = s_idle;
            end else begin
               data_nxt = shift_r[7:0];
               shift_nxt = {8'h00, shift_r[63:8]};
               left_nxt = left_r - LEN_ONE;
            end
         end
      endcase
   end

   // Serialiser registers
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         ser_state_r <= s_idle;
         left_r <= LEN_NONE;
         shift_r <= '0;
         rx_r <= 1'b0;
         type_r <= '0;
         data_r <= '0;
         cur_r <= '0;
      end else begin
         ser_state_r <= ser_state_nxt;
         left_r <= left_nxt;
         shift_r <= shift_nxt;
         rx_r <= rx_nxt;
         type_r <= type_nxt;
         data_r <= data_nxt;
         cur_r <= cur_nxt;
      end
   end

   assign o_msg_received = rx_r;
   assign o_msg_type = type_r;
   assign o_msg_data = data_r;

   // ==========================================================
   // Configuration management access
   logic [31:0] cfg_mem_r [NUM_WORDS];
   mgmt_state_e mgmt_state_r;
   mgmt_cnt_t cnt_r;
   logic op_write_r;
   logic override_r;
   logic hit_r;
   logic [IDX_W-1:0] idx_r;
   logic [9:0] dw_r;
   logic [31:0] wdata_r;
   logic [3:0] be_r;
   logic [31:0] rdata_r;
   logic done_r;

   // Decode of function and dword fields
   wire [DW_W-1:0] req_dw = i_mgmt_req.addr[DW_LSB +: DW_W];
   wire [FUNC_W-1:0] req_func = i_mgmt_req.addr[FUNC_LSB +: FUNC_W];
   wire req_hit = (int'(req_func) < NUM_FUNC) && (int'(req_dw) < NUM_DW);
   wire [IDX_W-1:0] req_idx = IDX_W'(int'(req_func) * NUM_DW + int'(req_dw));
   wire take = (mgmt_state_r == m_idle) && (i_mgmt_write || i_mgmt_read);
   wire finish = (mgmt_state_r == m_busy) && (cnt_r == LAT_LAST);
   wire [31:0] cur_word = hit_r ? cfg_mem_r[idx_r] : 32'h0000_0000;

   // Identity and class dwords are read-only unless overridden
   wire ro_dw = (dw_r == DW_ID) || (dw_r == DW_CLASS);
   wire may_write = hit_r && (!ro_dw || override_r);
   wire cfg_wr = finish && op_write_r && may_write;

   function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   // Access sequencer; the done cycle is spent in m_done, a cool-down in
   // which the still-raised strobe is ignored
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         mgmt_state_r <= m_idle;
         cnt_r <= '0;
         done_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         done_r <= finish;
         unique case (mgmt_state_r)
            m_idle: if (take) begin
               mgmt_state_r <= m_busy;
               cnt_r <= '0;
            end
            m_busy: if (finish) begin
               mgmt_state_r <= m_done;
               rdata_r <= op_write_r ? 32'h0000_0000 : cur_word;
            end else begin
               cnt_r <= cnt_r + CNT_STEP;
            end
            m_done: mgmt_state_r <= m_idle;
         endcase
      end
   end

   // Request capture; write wins when both strobes rise together
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         op_write_r <= 1'b0;
         override_r <= 1'b0;
         hit_r <= 1'b0;
         idx_r <= '0;
         dw_r <= '0;
         wdata_r <= '0;
         be_r <= '0;
      end else if (take) begin
         op_write_r <= i_mgmt_write;
         override_r <= i_root_port && i_mgmt_type1_override;
         hit_r <= req_hit;
         idx_r <= req_idx;
         dw_r <= req_dw;
         wdata_r <= i_mgmt_req.wdata;
         be_r <= i_mgmt_req.byte_en;
      end
   end

   // Configuration storage with byte-lane writes
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            cfg_mem_r[i] <= (i % NUM_DW == 0) ? ID_DWORD : 32'h0000_0000;
         end
      end else if (cfg_wr) begin
         cfg_mem_r[idx_r] <= merge_be(cfg_mem_r[idx_r], wdata_r, be_r);
      end
   end

   assign o_mgmt_read_data = rdata_r;
   assign o_mgmt_done = done_r;

   // ==========================================================
   // Checks
   a_ltr_length: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(rx_r) && type_r == TYPE_LTR |-> rx_r[*6] ##1 !rx_r)
      else $error("latency tolerance pulse not six cycles");

   a_obff_length: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(rx_r) && type_r == TYPE_OBFF |-> rx_r[*3] ##1 !rx_r)
      else $error("flush/fill pulse not three cycles");

   a_obff_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(rx_r) && type_r == TYPE_OBFF |-> ##2 data_r == cur_r.data[7:0])
      else $error("flush/fill code byte wrong");

   a_short_length: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(rx_r) && type_r >= TYPE_UNLOCK && type_r != TYPE_VDM0 && type_r != TYPE_VDM1
      |-> rx_r[*2] ##1 !rx_r)
      else $error("unlock or translation pulse not two cycles");

   a_vdm_data_len: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(rx_r) && (type_r == TYPE_VDM0 || type_r == TYPE_VDM1) && cur_r.has_data
      |-> rx_r[*8] ##1 !rx_r)
      else $error("vendor message with data not eight cycles");

   a_vdm_bare_len: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(rx_r) && (type_r == TYPE_VDM0 || type_r == TYPE_VDM1) && !cur_r.has_data
      |-> rx_r[*4] ##1 !rx_r ##0 $past(data_r) == cur_r.vendor_id[15:8])
      else $error("vendor message without data wrong");

   a_slot_payload: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(rx_r) && type_r == TYPE_SLOT_POWER
      |-> rx_r[*6] ##0 data_r == cur_r.data[31:24] ##1 !rx_r)
      else $error("slot power payload order wrong");

   a_id_bytes: assert property (@(posedge i_clock) disable iff (!i_nrst)
      $rose(rx_r) |-> data_r == cur_r.req_bus ##1 data_r == cur_r.req_devfn)
      else $error("requester id bytes out of order");

   a_type_stable: assert property (@(posedge i_clock) disable iff (!i_nrst)
      rx_r && $past(rx_r) |-> $stable(type_r))
      else $error("type code changed inside a pulse");

   // The last byte cycle must hand back a low cycle even when the queue holds more
   a_pulse_gap: assert property (@(posedge i_clock) disable iff (!i_nrst)
      ser_state_r == s_send && left_r == LEN_NONE |=> !rx_r)
      else $error("no gap between indications");

   a_done_timely: assert property (@(posedge i_clock) disable iff (!i_nrst)
      take |-> ##[1:MGMT_MAX] done_r)
      else $error("access done late");

   a_done_single: assert property (@(posedge i_clock) disable iff (!i_nrst)
      done_r |=> !done_r ##1 mgmt_state_r == m_idle)
      else $error("done not a single pulse");

   a_read_value: assert property (@(posedge i_clock) disable iff (!i_nrst)
      done_r && !op_write_r |-> rdata_r == cur_word)
      else $error("read data does not match storage");

   a_ro_protect: assert property (@(posedge i_clock) disable iff (!i_nrst)
      finish && op_write_r && hit_r && ro_dw && !override_r
      |=> $stable(cfg_mem_r[idx_r]))
      else $error("read-only dword was written");
endmodule
`default_nettype wire

// ---- include/cfg_msg_pkg.sv ----
`default_nettype none
package cfg_msg_pkg;

   // ==========================================================
   // Received message type codes
   localparam logic [4:0] TYPE_SLOT_POWER = 5'h0f;
   localparam logic [4:0] TYPE_LTR = 5'h10;
   localparam logic [4:0] TYPE_OBFF = 5'h11;
   localparam logic [4:0] TYPE_UNLOCK = 5'h12;
   localparam logic [4:0] TYPE_VDM0 = 5'h13;
   localparam logic [4:0] TYPE_VDM1 = 5'h14;
   localparam logic [4:0] TYPE_ATS_FIRST = 5'h15;
   localparam logic [4:0] TYPE_ATS_LAST = 5'h18;

   // ==========================================================
   // Indication lengths in cycles
   localparam logic [3:0] LEN_NONE = 4'h0;
   localparam logic [3:0] LEN_ONE = 4'h1;
   localparam logic [3:0] LEN_ID_ONLY = 4'h2;
   localparam logic [3:0] LEN_OBFF = 4'h3;
   localparam logic [3:0] LEN_VDM_BARE = 4'h4;
   localparam logic [3:0] LEN_PAYLOAD = 4'h6;
   localparam logic [3:0] LEN_VDM_DATA = 4'h8;

   // ==========================================================
   // Management address layout and protected dwords
   localparam int DW_LSB = 0;
   localparam int DW_W = 10;
   localparam int FUNC_LSB = 10;
   localparam int FUNC_W = 8;
   localparam logic [9:0] DW_ID = 10'h000;
   localparam logic [9:0] DW_CLASS = 10'h002;
   localparam logic [7:0] CNT_STEP = 8'h01;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [4:0] kind;
      logic [7:0] req_bus;
      logic [7:0] req_devfn;
      logic [15:0] vendor_id;
      logic has_data;
      logic [31:0] data;
   } msg_s;

   typedef struct packed {
      logic [17:0] addr;
      logic [31:0] wdata;
      logic [3:0] byte_en;
   } mgmt_req_s;

   typedef struct packed {
      logic [3:0] len;
      logic [63:0] bytes;
   } frame_s;

   typedef logic [7:0] mgmt_cnt_t;

   // Byte order of one indication, first byte in the low lane
   function automatic frame_s build_frame(input msg_s m);
      frame_s f;
      logic vdm;
      vdm = (m.kind == TYPE_VDM0) || (m.kind == TYPE_VDM1);
      // Only the first payload dword is ever carried
      f.bytes = vdm ? {m.data, m.vendor_id, m.req_devfn, m.req_bus}
                    : {16'h0000, m.data, m.req_devfn, m.req_bus};
      if (vdm) begin
         f.len = m.has_data ? LEN_VDM_DATA : LEN_VDM_BARE;
      end else if (m.kind == TYPE_LTR || m.kind == TYPE_SLOT_POWER) begin
         f.len = LEN_PAYLOAD;
      end else if (m.kind == TYPE_OBFF) begin
         f.len = LEN_OBFF;
      end else if (m.kind <= TYPE_ATS_LAST) begin
         f.len = LEN_ID_ONLY;
      end else begin
         f.len = LEN_NONE;
      end
      return f;
   endfunction

endpackage
`default_nettype wire

// ---- hw/msg_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module msg_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   function automatic logic [PTR_W-1:0] wrap_inc(input logic [PTR_W-1:0] p);
      return (p == PTR_LAST) ? '0 : PTR_W'(p + 1'b1);
   endfunction

   // ==========================================================
   // Storage and pointers
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic ready_r;
   wire push = i_in_valid && ready_r;
   wire pop = i_out_ready && (count_r != '0);

   // Ready is registered so the source sees a clean flop
   assign count_nxt = push && !pop ? CNT_W'(count_r + CNT_ONE)
                    : !push && pop ? CNT_W'(count_r - CNT_ONE) : count_r;
   assign o_in_ready = ready_r;
   assign o_out_valid = (count_r != '0);
   assign o_out_data = mem_r[rd_ptr_r];

   // Pointer and level update
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         ready_r <= 1'b1;
      end else begin
         if (push) wr_ptr_r <= wrap_inc(wr_ptr_r);
         if (pop) rd_ptr_r <= wrap_inc(rd_ptr_r);
         count_r <= count_nxt;
         ready_r <= (count_nxt != CNT_FULL);
      end
   end

   // Data words need no reset; valid is carried by the level
   always_ff @(posedge i_clock) begin
      if (push) mem_r[wr_ptr_r] <= i_in_data;
   end
endmodule
`default_nettype wire

// ---- sim/msg_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// User-side receiver of message indications
module msg_sink (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_pulse,
   input wire logic [4:0] i_type,
   input wire logic [7:0] i_data
);
   logic [4:0] type_q[$];
   logic [67:0] frame_q[$];
   logic [3:0] len_r;
   logic [63:0] bytes_r;
   logic [4:0] type_r;
   int bad_type = 0;
   int gap = 99;
   int min_gap = 99;

   // Capture on every edge; there is no stall, so a missed cycle is a lost byte
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         len_r = 4'h0;
         bytes_r = 64'h0;
      end else if (i_pulse === 1'b1) begin
         if (len_r == 4'h0) begin
            type_r = i_type;
            if (gap < min_gap) min_gap = gap;
         end else if (i_type !== type_r) begin
            bad_type++;
         end
         bytes_r[8*len_r +: 8] = i_data;
         len_r++;
         gap = 0;
      end else begin
         if (len_r != 4'h0) begin
            type_q.push_back(type_r);
            frame_q.push_back({len_r, bytes_r});
         end
         len_r = 4'h0;
         bytes_r = 64'h0;
         gap++;
      end
   end
endmodule
`default_nettype wire

// ---- sim/cfg_msg_and_mgmt_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfg_msg_and_mgmt_port_tb_top;
   import cfg_msg_pkg::*;
   localparam int LAT = 2;
   // Arbitrary identity value
   localparam logic [31:0] ID = 32'h0a1b_2c3d;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic msg_valid = 1'b0;
   msg_s msg = '0;
   logic root_port = 1'b0;
   mgmt_req_s mgmt_req = '0;
   logic mgmt_write = 1'b0;
   logic mgmt_read = 1'b0;
   logic type1_override = 1'b0;
   logic msg_ready, msg_received, mgmt_done;
   logic [4:0] msg_type;
   logic [7:0] msg_data;
   logic [31:0] mgmt_read_data;
   logic saw_full = 1'b0;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;

   // ==========================================================
   // Design and user-side receiver
   cfg_msg_port #(.NUM_FUNC(2), .NUM_DW(16), .MGMT_LAT(LAT), .FIFO_DEPTH(8), .ID_DWORD(ID)) dut_u (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_msg_valid(msg_valid), .i_msg(msg),
      .o_msg_ready(msg_ready), .o_msg_received(msg_received), .o_msg_type(msg_type),
      .o_msg_data(msg_data), .i_root_port(root_port), .i_mgmt_req(mgmt_req),
      .i_mgmt_write(mgmt_write), .i_mgmt_read(mgmt_read), .i_mgmt_type1_override(type1_override),
      .o_mgmt_read_data(mgmt_read_data), .o_mgmt_done(mgmt_done));
   msg_sink sink_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_pulse(msg_received),
      .i_type(msg_type), .i_data(msg_data));

   // ==========================================================
   // Clock and hang guard; the whole run needs well under 2000 cycles
   initial begin
      forever #12.5 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end

   task automatic chk(input logic [67:0] got, input logic [67:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // Message side: expected length and byte lanes, first byte lowest
   function automatic logic [67:0] exp_of(input msg_s m);
      logic [3:0] n;
      logic [63:0] b;
      b = {16'h0000, m.data, m.req_devfn, m.req_bus};
      if (m.kind == 5'd19 || m.kind == 5'd20) begin
         b = {m.data, m.vendor_id, m.req_devfn, m.req_bus};
         n = m.has_data ? 4'h8 : 4'h4;
      end else if (m.kind == 5'd15 || m.kind == 5'd16) n = 4'h6;
      else if (m.kind == 5'd17) n = 4'h3;
      else if (m.kind <= 5'd24) n = 4'h2;
      else n = 4'h0;
      b = b & ~({64{1'b1}} << (8 * n));
      return {n, b};
   endfunction

   // Offer held from one falling edge until a rising edge that sees ready
   task automatic send_msg(input msg_s m);
      int w;
      @(negedge i_clock);
      msg_valid = 1'b1;
      msg = m;
      w = 0;
      while (msg_ready !== 1'b1 && w < 200) begin
         saw_full = 1'b1;
         @(negedge i_clock);
         w++;
      end
   endtask

   // Every type class, back to back so the buffer fills; reserved codes vanish
   task automatic test_msg();
      logic [4:0] k[14] = '{5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h13, 5'h14, 5'h14,
                            5'h15, 5'h18, 5'h00, 5'h0e, 5'h19, 5'h1f};
      msg_s m;
      msg_s sent[$];
      int w;
      for (int i = 0; i < 14; i++) begin
         m = {k[i], 8'(8'h20 + i), 8'(8'ha0 + i), 16'hbe00 | 16'(i), i[0], 32'h8877_6655 ^ {4{8'(i)}}};
         send_msg(m);
         if (k[i] <= 5'h18) sent.push_back(m);
      end
      @(negedge i_clock);
      msg_valid = 1'b0;
      for (w = 0; w < 600 && sink_u.frame_q.size() < 12; w++) @(negedge i_clock);
      repeat (12) @(negedge i_clock);
      chk(68'(sink_u.frame_q.size()), 68'd12, "indication count");
      chk(68'(saw_full), 68'h1, "offers stalled only at input");
      for (int j = 0; j < 12 && j < sink_u.frame_q.size(); j++) begin
         chk(68'(sink_u.type_q[j]), 68'(sent[j].kind), "type code");
         chk(sink_u.frame_q[j], exp_of(sent[j]), "length and bytes");
      end
      chk(68'(sink_u.min_gap >= 1), 68'h1, "low gap between pulses");
      chk(68'(sink_u.bad_type), 68'h0, "type stable in pulse");
      $display("test_msg done");
   endtask

   // ==========================================================
   // Management side: request held until done, strobe dropped the cycle after
   task automatic mgmt(input logic wr, input logic [7:0] f, input logic [9:0] dw, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
      int lat;
      @(negedge i_clock);
      mgmt_req = '{addr: {f, dw}, wdata: d, byte_en: be};
      mgmt_write = wr;
      mgmt_read = !wr;
      lat = 0;
      do begin
         @(negedge i_clock);
         lat++;
      end while (mgmt_done !== 1'b1 && lat < 20);
      rd = mgmt_read_data;
      chk(68'(lat), 68'(LAT + 1), "done latency");
      @(negedge i_clock);
      mgmt_write = 1'b0;
      mgmt_read = 1'b0;
   endtask

   task automatic wr_dw(input logic [7:0] f, input logic [9:0] dw, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] rd;
      mgmt(1'b1, f, dw, d, be, rd);
      chk(68'(rd), 68'h0, "write returns no data");
   endtask

   task automatic rd_chk(input logic [7:0] f, input logic [9:0] dw, input logic [31:0] exp);
      logic [31:0] rd;
      mgmt(1'b0, f, dw, 32'h0, 4'h0, rd);
      chk(68'(rd), 68'(exp), "read data");
   endtask

   task automatic test_mgmt();
      rd_chk(8'h00, 10'h000, ID);
      rd_chk(8'h01, 10'h000, ID);
      wr_dw(8'h00, 10'h001, 32'hcafe_f00d, 4'hf);
      rd_chk(8'h00, 10'h001, 32'hcafe_f00d);
      wr_dw(8'h00, 10'h004, 32'ha5a5_5a5a, 4'h5);
      rd_chk(8'h00, 10'h004, 32'h00a5_005a);
      rd_chk(8'h01, 10'h004, 32'h0);
      wr_dw(8'h01, 10'h004, 32'h1122_3344, 4'hf);
      rd_chk(8'h01, 10'h004, 32'h1122_3344);
      rd_chk(8'h00, 10'h004, 32'h00a5_005a);
      wr_dw(8'h02, 10'h001, 32'hffff_ffff, 4'hf);
      rd_chk(8'h02, 10'h001, 32'h0);
      rd_chk(8'h00, 10'h020, 32'h0);
      $display("test_mgmt done");
   endtask

   // Read-only dwords move only with root mode and the override together
   task automatic test_override();
      type1_override = 1'b1;
      wr_dw(8'h00, 10'h002, 32'h0bad_0bad, 4'hf);
      rd_chk(8'h00, 10'h002, 32'h0);
      root_port = 1'b1;
      type1_override = 1'b0;
      wr_dw(8'h00, 10'h002, 32'h0bad_0bad, 4'hf);
      rd_chk(8'h00, 10'h002, 32'h0);
      type1_override = 1'b1;
      wr_dw(8'h01, 10'h000, 32'h5555_aaaa, 4'hf);
      rd_chk(8'h01, 10'h000, 32'h5555_aaaa);
      rd_chk(8'h00, 10'h000, ID);
      type1_override = 1'b0;
      root_port = 1'b0;
      $display("test_override done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge i_clock);
      chk(68'({msg_ready, msg_received, mgmt_done}), 68'h4, "reset outputs");
      i_nrst = 1'b1;
      test_msg();
      test_mgmt();
      test_override();
      results();
   end
endmodule
`default_nettype wire
